// ### design/meas_irq_consts.svh
`ifndef MEAS_IRQ_CONSTS_SVH
`define MEAS_IRQ_CONSTS_SVH

// Register byte offsets (printed offsets are multiples of four)
`define OFS_ENABLE_A        10'h068
`define OFS_ENABLE_B        10'h10C
`define OFS_THRESH_CLEAR    10'h108
`define OFS_STATUS_A        10'h110
`define OFS_STATUS_B        10'h114
`define OFS_CLEAR_A         10'h118

// Implemented bit masks; every other position reads as zero
`define MASK_A              32'hFF03_1FFF
`define MASK_B              32'h0FFE_0FFE

// Field positions
`define POS_DIFF_LSB        24
`define POS_EXC_SEQ         17
`define POS_EXC_INT         16
`define POS_UPPER_LSB       17
`define POS_LOWER_LSB       1
`define POS_LOWER_MSB       11
`define POS_UPPER_MSB       27

`define RESET_WORD          32'h0000_0000

`endif

// ### design/meas_irq_pkg.sv
package meas_irq_pkg;

    // Generic 32-bit register word, used for the enable, status, clear and read data words
    typedef logic [31:0] word_t;

    typedef struct packed {
        logic [9:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } bus_req_t;

    typedef struct packed {
        word_t group_a;
        word_t group_b;
    } event_pair_t;

endpackage

// ### design/measurement_irq_enable_clear.sv
// What this block does
// - Writing one to upper clear bits 27..17 clears that upper threshold flag.
// - Writing one to lower clear bits 11..1 clears that lower threshold flag.
// - A zero written to any clear bit leaves its flag unchanged.
// - Reserved positions of clear and enable registers always read zero.
// - The threshold clear register resets to all zeros.
// - Enable A bits 31..24 enable differential unit 4..1 upper/lower events.
// - Enable A bit 17 gates exceptional sequence, bit 16 exceptional interrupt.
// - Enable A bits 12..0 gate port, monitor, supply and battery events.
// - Enable B bits 27..17 gate upper threshold events in channel order.
// - Enable B bits 11..1 gate lower threshold events, same order.
// - Enable one lets the event interrupt; zero blocks it.
// - Both enable registers reset to zero, all interrupts disabled.
// - Enable A decodes at 0x68, enable B at 0x10C.
`timescale 1ns/10ps
`include "meas_irq_consts.svh"

module measurement_irq_enable_clear (
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    input  wire logic [9:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [31:0] rdata,
    input  wire logic [31:0] event_a,
    input  wire logic [31:0] event_b,
    output logic             irq
);

    meas_irq_pkg::bus_req_t    req;
    meas_irq_pkg::event_pair_t ev;
    meas_irq_pkg::word_t       enable_a;
    meas_irq_pkg::word_t       enable_b;
    meas_irq_pkg::word_t       status_a;
    meas_irq_pkg::word_t       status_b;
    meas_irq_pkg::word_t       clear_a;
    meas_irq_pkg::word_t       clear_b;
    meas_irq_pkg::word_t       next_rdata;
    logic                      next_irq;

    assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};
    assign ev  = '{group_a: event_a & `MASK_A, group_b: event_b & `MASK_B};

    // Clear strobes exist for one cycle only, no storage behind them
    always_comb begin
        clear_a = `RESET_WORD;
        clear_b = `RESET_WORD;
        if (req.wr && req.addr == `OFS_CLEAR_A) begin
            clear_a = req.wdata & `MASK_A;
        end
        if (req.wr && req.addr == `OFS_THRESH_CLEAR) begin
            clear_b = req.wdata & `MASK_B;
        end
    end

    // Enable registers
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            enable_a <= `RESET_WORD;
            enable_b <= `RESET_WORD;
        end else if (req.wr) begin
            if (req.addr == `OFS_ENABLE_A) begin
                enable_a <= req.wdata & `MASK_A;
            end
            if (req.addr == `OFS_ENABLE_B) begin
                enable_b <= req.wdata & `MASK_B;
            end
        end
    end

    // Sticky status: a new event wins over a clear in the same cycle
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            status_a <= `RESET_WORD;
            status_b <= `RESET_WORD;
        end else begin
            status_a <= (status_a & ~clear_a) | ev.group_a;
            status_b <= (status_b & ~clear_b) | ev.group_b;
        end
    end

    always_comb begin
        next_rdata = `RESET_WORD;
        if (req.rd) begin
            case (req.addr)
                `OFS_ENABLE_A: next_rdata = enable_a;
                `OFS_ENABLE_B: next_rdata = enable_b;
                `OFS_STATUS_A: next_rdata = status_a;
                `OFS_STATUS_B: next_rdata = status_b;
                default:       next_rdata = `RESET_WORD;
            endcase
        end
    end

    assign next_irq = |((status_a & enable_a) | (status_b & enable_b));

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rdata <= `RESET_WORD;
        end else begin
            rdata <= next_rdata;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            irq <= 1'b0;
        end else begin
            irq <= next_irq;
        end
    end

    localparam meas_irq_pkg::word_t keep_mask_a = `MASK_A;
    localparam meas_irq_pkg::word_t keep_mask_b = `MASK_B;

    a_irq_follows: assert property (@(posedge clk_sys)
        disable iff (!rst_b)
        irq == $past(next_irq))
        else $error("irq does not follow enabled status");

    a_enable_zero_block: assert property (@(posedge clk_sys)
        disable iff (!rst_b)
        (enable_a == 32'h0 && enable_b == 32'h0) |=> !irq)
        else $error("irq with all enables clear");

    a_event_beats_clear: assert property (@(posedge clk_sys)
        disable iff (!rst_b)
        (ev.group_b[`POS_UPPER_LSB] && clear_b[`POS_UPPER_LSB])
        |=> status_b[`POS_UPPER_LSB])
        else $error("clear beat a simultaneous event");

    a_upper_clear: assert property (@(posedge clk_sys)
        disable iff (!rst_b)
        (clear_b[20] && !ev.group_b[20]) |=> !status_b[20])
        else $error("upper clear failed");

    a_lower_clear: assert property (@(posedge clk_sys)
        disable iff (!rst_b)
        (clear_b[1] && !ev.group_b[1]) |=> !status_b[1])
        else $error("lower clear failed");

    a_zero_keeps: assert property (@(posedge clk_sys)
        disable iff (!rst_b)
        (status_b[11] && !clear_b[11]) |=> status_b[11])
        else $error("flag lost without clear");

    a_reserved_zero: assert property (@(posedge clk_sys)
        disable iff (!rst_b)
        (enable_a & ~`MASK_A) == 32'h0 && (enable_b & ~`MASK_B) == 32'h0)
        else $error("reserved enable bit set");

    a_clear_masked: assert property (@(posedge clk_sys)
        disable iff (!rst_b)
        (clear_b & ~keep_mask_b) == 32'h0)
        else $error("reserved clear bit acted");

    a_enable_readback: assert property (@(posedge clk_sys)
        disable iff (!rst_b)
        (req.rd && req.addr == `OFS_ENABLE_B) |=> rdata == $past(enable_b))
        else $error("enable b readback wrong");

    a_clear_reads_zero: assert property (@(posedge clk_sys)
        disable iff (!rst_b)
        (req.rd && req.addr == `OFS_THRESH_CLEAR) |=> rdata == 32'h0)
        else $error("clear register read nonzero");

    a_enable_a_write: assert property (@(posedge clk_sys)
        disable iff (!rst_b)
        (req.wr && req.addr == `OFS_ENABLE_A)
        |=> enable_a == ($past(req.wdata) & `MASK_A))
        else $error("enable a write did not land");

    a_enable_b_write: assert property (@(posedge clk_sys)
        disable iff (!rst_b)
        (req.wr && req.addr == `OFS_ENABLE_B)
        |=> enable_b == ($past(req.wdata) & `MASK_B))
        else $error("enable b write did not land");

    a_readback_a: assert property (@(posedge clk_sys)
        disable iff (!rst_b)
        (req.rd && req.addr == `OFS_ENABLE_A) |=> rdata == $past(enable_a))
        else $error("enable a readback wrong");

    a_status_a_read: assert property (@(posedge clk_sys)
        disable iff (!rst_b)
        (req.rd && req.addr == `OFS_STATUS_A) |=> rdata == $past(status_a))
        else $error("status a readback wrong");

    a_status_b_read: assert property (@(posedge clk_sys)
        disable iff (!rst_b)
        (req.rd && req.addr == `OFS_STATUS_B) |=> rdata == $past(status_b))
        else $error("status b readback wrong");

    a_clear_a_zero: assert property (@(posedge clk_sys)
        disable iff (!rst_b)
        (req.rd && req.addr == `OFS_CLEAR_A) |=> rdata == 32'h0)
        else $error("clear a register read nonzero");

    a_idle_rdata: assert property (@(posedge clk_sys)
        disable iff (!rst_b)
        !req.rd |=> rdata == 32'h0)
        else $error("read data outside a read cycle");

    a_status_wr_ignored: assert property (@(posedge clk_sys)
        disable iff (!rst_b)
        (req.wr && req.addr == `OFS_STATUS_B)
        |=> ($past(status_b) & ~status_b) == 32'h0)
        else $error("write to status dropped a flag");

    a_irq_drop: assert property (@(posedge clk_sys)
        disable iff (!rst_b)
        ((status_a & enable_a) == 32'h0 && (status_b & enable_b) == 32'h0)
        |=> !irq)
        else $error("irq stayed high with no enabled flag");

    a_exc_seq_gate: assert property (@(posedge clk_sys)
        disable iff (!rst_b)
        (status_a[`POS_EXC_SEQ] && enable_a[`POS_EXC_SEQ]) |=> irq)
        else $error("exceptional sequence flag gave no irq");

    a_diff_gate: assert property (@(posedge clk_sys)
        disable iff (!rst_b)
        (status_a[`POS_DIFF_LSB] && enable_a[`POS_DIFF_LSB]) |=> irq)
        else $error("differential flag gave no irq");

    a_port20_gate: assert property (@(posedge clk_sys)
        disable iff (!rst_b)
        (status_a[12] && enable_a[12]) |=> irq)
        else $error("port flag gave no irq");

    a_supply_up_gate: assert property (@(posedge clk_sys)
        disable iff (!rst_b)
        (status_b[`POS_UPPER_LSB] && enable_b[`POS_UPPER_LSB]) |=> irq)
        else $error("supply upper flag gave no irq");

    a_supply_lo_gate: assert property (@(posedge clk_sys)
        disable iff (!rst_b)
        (status_b[`POS_LOWER_LSB] && enable_b[`POS_LOWER_LSB]) |=> irq)
        else $error("supply lower flag gave no irq");

    // Every lower threshold channel, one bit at a time
    for (genvar gl = `POS_LOWER_LSB; gl <= `POS_LOWER_MSB; gl++) begin : g_low
        a_low_bit_clear: assert property (@(posedge clk_sys)
            disable iff (!rst_b)
            (clear_b[gl] && !ev.group_b[gl]) |=> !status_b[gl])
            else $error("lower threshold flag not cleared");

        a_low_bit_keep: assert property (@(posedge clk_sys)
            disable iff (!rst_b)
            (status_b[gl] && !clear_b[gl]) |=> status_b[gl])
            else $error("lower threshold flag lost");

        a_low_bit_event: assert property (@(posedge clk_sys)
            disable iff (!rst_b)
            ev.group_b[gl] |=> status_b[gl])
            else $error("lower threshold event not latched");

        a_low_bit_gate: assert property (@(posedge clk_sys)
            disable iff (!rst_b)
            (status_b[gl] && enable_b[gl]) |=> irq)
            else $error("enabled lower flag gave no irq");
    end

    // Every upper threshold channel, one bit at a time
    for (genvar gu = `POS_UPPER_LSB; gu <= `POS_UPPER_MSB; gu++) begin : g_up
        a_up_bit_clear: assert property (@(posedge clk_sys)
            disable iff (!rst_b)
            (clear_b[gu] && !ev.group_b[gu]) |=> !status_b[gu])
            else $error("upper threshold flag not cleared");

        a_up_bit_keep: assert property (@(posedge clk_sys)
            disable iff (!rst_b)
            (status_b[gu] && !clear_b[gu]) |=> status_b[gu])
            else $error("upper threshold flag lost");

        a_up_bit_event: assert property (@(posedge clk_sys)
            disable iff (!rst_b)
            ev.group_b[gu] |=> status_b[gu])
            else $error("upper threshold event not latched");

        a_up_bit_gate: assert property (@(posedge clk_sys)
            disable iff (!rst_b)
            (status_b[gu] && enable_b[gu]) |=> irq)
            else $error("enabled upper flag gave no irq");
    end

    // First event group, one bit at a time
    for (genvar ga = 0; ga < 32; ga++) begin : g_grp_a
        a_grp_a_reserved: assert property (@(posedge clk_sys)
            disable iff (!rst_b)
            !keep_mask_a[ga] |-> (!enable_a[ga] && !status_a[ga]))
            else $error("reserved group a bit set");

        a_grp_a_gate: assert property (@(posedge clk_sys)
            disable iff (!rst_b)
            (status_a[ga] && enable_a[ga]) |=> irq)
            else $error("enabled group a flag gave no irq");

        a_grp_a_clear: assert property (@(posedge clk_sys)
            disable iff (!rst_b)
            (clear_a[ga] && !ev.group_a[ga]) |=> !status_a[ga])
            else $error("group a flag not cleared");

        a_grp_a_keep: assert property (@(posedge clk_sys)
            disable iff (!rst_b)
            (status_a[ga] && !clear_a[ga]) |=> status_a[ga])
            else $error("group a flag lost");
    end

    // Second event group: reserved positions and gating
    for (genvar gb = 0; gb < 32; gb++) begin : g_grp_b
        a_grp_b_reserved: assert property (@(posedge clk_sys)
            disable iff (!rst_b)
            !keep_mask_b[gb] |-> (!enable_b[gb] && !status_b[gb]))
            else $error("reserved group b bit set");

        a_grp_b_gate: assert property (@(posedge clk_sys)
            disable iff (!rst_b)
            (status_b[gb] && enable_b[gb]) |=> irq)
            else $error("enabled group b flag gave no irq");
    end

    // Enable bits change only on a write to their own register
    for (genvar ge = 0; ge < 32; ge++) begin : g_en
        a_en_a_hold: assert property (@(posedge clk_sys)
            disable iff (!rst_b)
            !(req.wr && req.addr == `OFS_ENABLE_A) |=> $stable(enable_a[ge]))
            else $error("enable a bit changed without a write");

        a_en_b_hold: assert property (@(posedge clk_sys)
            disable iff (!rst_b)
            !(req.wr && req.addr == `OFS_ENABLE_B) |=> $stable(enable_b[ge]))
            else $error("enable b bit changed without a write");
    end

    c_irq_raised: cover property (@(posedge clk_sys) disable iff (!rst_b)
        !irq ##1 irq);
    c_irq_dropped: cover property (@(posedge clk_sys) disable iff (!rst_b)
        irq ##1 !irq);
    c_clear_collide: cover property (@(posedge clk_sys) disable iff (!rst_b)
        |(clear_b & ev.group_b));
    c_group_a_irq: cover property (@(posedge clk_sys) disable iff (!rst_b)
        |(status_a & enable_a));
    c_zero_write: cover property (@(posedge clk_sys) disable iff (!rst_b)
        req.wr && req.addr == `OFS_THRESH_CLEAR && req.wdata == 32'h0);

endmodule

// ### testbench/meas_event_source.sv
`timescale 1ns/10ps
module meas_event_source (
    input  wire logic        clk_sys,
    input  wire logic [31:0] fire_a,
    input  wire logic [31:0] fire_b,
    output logic      [31:0] event_a,
    output logic      [31:0] event_b
);
    // Events leave the measurement unit as registered one-cycle pulses
    always_ff @(posedge clk_sys) begin
        event_a <= fire_a;
        event_b <= fire_b;
    end
endmodule

// ### testbench/measurement_irq_enable_clear_tb.sv
`timescale 1ns/10ps
module measurement_irq_enable_clear_tb;
    logic        clk_sys;
    logic        rst_b;
    logic [9:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
    logic [31:0] rdata;
    logic [31:0] event_a;
    logic [31:0] event_b;
    logic [31:0] fire_a;
    logic [31:0] fire_b;
    logic        irq;
    int          failures;
    int          n_checks;
    int          cycles;

    measurement_irq_enable_clear dut (.clk_sys(clk_sys), .rst_b(rst_b),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .event_a(event_a), .event_b(event_b), .irq(irq));
    meas_event_source src (.clk_sys(clk_sys), .fire_a(fire_a),
        .fire_b(fire_b), .event_a(event_a), .event_b(event_b));

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task wr_reg(input logic [9:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        addr <= a;
        wdata <= d;
        wr <= 1'h1;
        @(posedge clk_sys);
        wr <= 1'h0;
    endtask
    task rd_chk(input logic [9:0] a, input logic [31:0] e);
        @(posedge clk_sys);
        addr <= a;
        rd <= 1'h1;
        @(posedge clk_sys);
        rd <= 1'h0;
        #1 chk(rdata, e);
    endtask
    // Returns once the event has had time to reach the request line
    task fire(input logic [31:0] a, input logic [31:0] b);
        @(posedge clk_sys);
        fire_a <= a;
        fire_b <= b;
        @(posedge clk_sys);
        fire_a <= 32'h0;
        fire_b <= 32'h0;
        repeat (2) @(posedge clk_sys);
        #1;
    endtask
    task t_map;
        rd_chk(10'h068, 32'h0);
        rd_chk(10'h10C, 32'h0);
        rd_chk(10'h108, 32'h0);
        wr_reg(10'h068, 32'hFFFF_FFFF);
        wr_reg(10'h10C, 32'hFFFF_FFFF);
        rd_chk(10'h068, 32'hFF03_1FFF);
        rd_chk(10'h10C, 32'h0FFE_0FFE);
        wr_reg(10'h108, 32'hFFFF_FFFF);
        rd_chk(10'h108, 32'h0);
        rd_chk(10'h200, 32'h0);
        wr_reg(10'h068, 32'h0);
    endtask
    task t_thresh;
        wr_reg(10'h10C, 32'h0002_0002);
        fire(32'h0, 32'h001E_0FFE);
        chk({31'h0, irq}, 32'h1);
        wr_reg(10'h108, 32'h0);
        rd_chk(10'h114, 32'h001E_0FFE);
        wr_reg(10'h108, 32'h0002_0002);
        @(posedge clk_sys);
        #1 chk({31'h0, irq}, 32'h0);
        rd_chk(10'h114, 32'h001C_0FFC);
        wr_reg(10'h108, 32'h001C_0FFC);
        rd_chk(10'h114, 32'h0);
    endtask
    task t_group_a;
        fire(32'h0000_1001, 32'h0);
        chk({31'h0, irq}, 32'h0);
        wr_reg(10'h068, 32'h8001_0000);
        fire(32'h8001_0000, 32'h0);
        chk({31'h0, irq}, 32'h1);
        wr_reg(10'h118, 32'h8001_0000);
        rd_chk(10'h110, 32'h0000_1001);
        chk({31'h0, irq}, 32'h0);
    endtask
    task stop_test;
        if (failures == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        clk_sys = 1'h0;
        forever #50 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 2000) begin
            failures++;
            stop_test;
        end
    end
    initial begin
        {rst_b, addr, wdata, wr, rd, fire_a, fire_b} = '0;
        repeat (20) @(posedge clk_sys);
        rst_b <= 1'h1;
        t_map;
        t_thresh;
        t_group_a;
        stop_test;
    end
endmodule
